// file: common/cbbc_pkg.sv
// Shared constants for the conditional branch and bit-field change unit
package cbbc_pkg;

    // ****************************************
    // Status word bit positions
    // ****************************************
    localparam int BIT_C = 0;
    localparam int BIT_V = 1;
    localparam int BIT_Z = 2;
    localparam int BIT_N = 3;
    localparam int BIT_U = 4;
    localparam int BIT_E = 5;
    localparam int BIT_L = 6;

    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [15:0] PC_STEP      = 16'h0001;

    // ****************************************
    // Condition selector encodings
    // ****************************************
    localparam logic [3:0] COND_CC = 4'h0;
    localparam logic [3:0] COND_CS = 4'h1;
    localparam logic [3:0] COND_EQ = 4'h2;
    localparam logic [3:0] COND_GE = 4'h3;
    localparam logic [3:0] COND_GT = 4'h4;
    localparam logic [3:0] COND_HI = 4'h5;
    localparam logic [3:0] COND_LE = 4'h6;
    localparam logic [3:0] COND_LS = 4'h7;
    localparam logic [3:0] COND_LT = 4'h8;
    localparam logic [3:0] COND_NE = 4'h9;
    localparam logic [3:0] COND_NN = 4'ha;
    localparam logic [3:0] COND_NR = 4'hb;

    // ****************************************
    // Branch timing in oscillator cycles
    // ****************************************
    localparam logic [2:0] BR_TAKEN_CYC = 3'h6;
    localparam logic [2:0] BR_NOT_CYC   = 3'h4;
    localparam logic [2:0] CNT_ONE      = 3'h1;

    // ****************************************
    // APB register map
    // ****************************************
    localparam logic [7:0] ADDR_MODE   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PC     = 8'h08;
    localparam logic [7:0] ADDR_INFO   = 8'h0c;
    localparam int MODE_CC_BIT   = 0;
    localparam int INFO_BUSY     = 0;
    localparam int INFO_ILLEGAL  = 1;
    localparam int INFO_TAKEN    = 2;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_BRANCH = 3'b001,
        ST_READ   = 3'b010,
        ST_WRITE  = 3'b011
    } cbbc_state_t;

endpackage

// file: hw/cbbc_cond_eval.sv
// Condition code evaluation for the short conditional branch
`timescale 1ns/10ps
module cbbc_cond_eval (
    input  wire logic [15:0] flags,
    input  wire logic [3:0]  condSel,
    input  wire logic        ccMode,
    output logic             condTrue,
    output logic             condLegal
);
    logic c;
    logic v;
    logic z;
    logic n;
    logic nxv;
    logic nrm;

    assign c   = flags[cbbc_pkg::BIT_C];
    assign v   = flags[cbbc_pkg::BIT_V];
    assign z   = flags[cbbc_pkg::BIT_Z];
    assign n   = flags[cbbc_pkg::BIT_N];
    assign nxv = n ^ v;
    assign nrm = z | (~flags[cbbc_pkg::BIT_U] & ~flags[cbbc_pkg::BIT_E]);

    always_comb begin
        condTrue  = 1'b0;
        condLegal = 1'b1;
        case (condSel)
            cbbc_pkg::COND_CC: condTrue = ~c;
            cbbc_pkg::COND_CS: condTrue = c;
            cbbc_pkg::COND_HI: condTrue = ~c & ~z;
            cbbc_pkg::COND_LS: condTrue = c | z;
            cbbc_pkg::COND_EQ: condTrue = z;
            cbbc_pkg::COND_NE: condTrue = ~z;
            cbbc_pkg::COND_GE: condTrue = ~nxv;
            cbbc_pkg::COND_LT: condTrue = nxv;
            cbbc_pkg::COND_GT: condTrue = ~(z | nxv);
            cbbc_pkg::COND_LE: condTrue = z | nxv;
            cbbc_pkg::COND_NN: condTrue = ~nrm;
            cbbc_pkg::COND_NR: condTrue = nrm;
            default:           condLegal = 1'b0;
        endcase
        // Unsigned forms need the mode bit; refused ones fall through
        if ((condSel == cbbc_pkg::COND_CC || condSel == cbbc_pkg::COND_CS ||
             condSel == cbbc_pkg::COND_HI || condSel == cbbc_pkg::COND_LS)
            && !ccMode) begin
            condTrue  = 1'b0;
            condLegal = 1'b0;
        end
    end
endmodule // cbbc_cond_eval

// file: hw/cbbc_bit_alu.sv
// Masked test and complement datapath
`timescale 1ns/10ps
module cbbc_bit_alu #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] value,
    input  wire logic [WIDTH-1:0] mask,
    output logic [WIDTH-1:0]      result,
    output logic                  allSet
);
    logic [WIDTH-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign hit[i]    = ~mask[i] | value[i];
            assign result[i] = value[i] ^ mask[i];
        end
    endgenerate

    // Empty mask leaves every term high, so carry comes out set
    assign allSet = &hit;
endmodule // cbbc_bit_alu

// file: hw/cbbc_core.sv
// Conditional branch and bit-field change execution unit with APB slave
// What this block does
// - Taken branch loads next address plus displacement
// - Untaken branch steps program counter by one
// - Seven-bit offset sign-extended to sixteen bits
// - Carry conditions from carry and zero flags
// - Signed and equality conditions from N,V,Z
// - Greater-than and less-equal use Z or N^V
// - Normalized conditions use Z, U, E
// - Unsigned conditions only with mode bit set
// - Branch never alters the status word
// - One word; six cycles taken, four not
// - Mask bits select destination bits to test
// - Carry set when all selected bits one
// - Invert selected bits, write back same place
// - Exactly one read then one write
// - Zero mask leaves value, sets carry
// - Limit flag set on limited source move
// - Status destination inverts only masked bits
// - Carry bit0, negative bit3, extension bit5
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module cbbc_core #(
    parameter int AW = 8
) (
    input  wire logic          clock,
    input  wire logic          srst,
    input  wire logic [AW-1:0] paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          instrValid,
    output logic               instrReady,
    input  wire logic          instrIsBranch,
    input  wire logic [3:0]    condSel,
    input  wire logic [6:0]    offset,
    input  wire logic [15:0]   bfMask,
    input  wire logic          bfToStatus,
    input  wire logic [15:0]   bfAddr,
    input  wire logic          limitEvent,
    output logic [15:0]        pcOut,
    output logic               pcLoad,
    output logic               instrDone,
    output logic               branchTaken,
    output logic               dataReq,
    output logic               dataWe,
    output logic [15:0]        dataAddr,
    output logic [15:0]        dataWdata,
    input  wire logic [15:0]   dataRdata,
    input  wire logic          dataAck
);
    // ****************************************
    // State and storage
    // ****************************************
    cbbc_pkg::cbbc_state_t stateFf;
    logic [15:0] statusFf;
    logic [15:0] pcFf;
    logic [15:0] tgtFf;
    logic [15:0] maskFf;
    logic [15:0] opValFf;
    logic [2:0]  cntFf;
    logic        ccModeFf;
    logic        illegalFf;
    logic        takenFf;
    logic        toStatusFf;
    logic        limFf;
    logic        pcLoadFf;
    logic        doneFf;
    logic        dataReqFf;
    logic        dataWeFf;
    logic [15:0] dataAddrFf;
    logic [15:0] dataWdataFf;

    logic        condTrue;
    logic        condLegal;
    logic        accept;
    logic        acceptBr;
    logic [15:0] sextOff;
    logic [15:0] branchTarget;
    logic [15:0] aluIn;
    logic [15:0] aluOut;
    logic        allSet;
    logic        apbWr;
    logic        memDone;
    logic        stDone;
    logic [15:0] nxt_status;
    localparam logic [15:0] PC_STEP_W = cbbc_pkg::PC_STEP;
    localparam logic [2:0]  CNT_W     = cbbc_pkg::CNT_ONE;

    cbbc_cond_eval u_cond (
        .flags     (statusFf),
        .condSel   (condSel),
        .ccMode    (ccModeFf),
        .condTrue  (condTrue),
        .condLegal (condLegal)
    );

    assign aluIn = (stateFf == cbbc_pkg::ST_READ && !toStatusFf) ?
                   dataRdata : opValFf;

    cbbc_bit_alu #(.WIDTH(16)) u_alu (
        .value  (aluIn),
        .mask   (maskFf),
        .result (aluOut),
        .allSet (allSet)
    );

    assign instrReady   = (stateFf == cbbc_pkg::ST_IDLE);
    assign accept       = instrValid && instrReady;
    assign acceptBr     = accept && instrIsBranch;
    assign sextOff      = {{9{offset[6]}}, offset};
    assign branchTarget = pcFf + PC_STEP_W + sextOff;
    assign memDone = (stateFf == cbbc_pkg::ST_WRITE) && !toStatusFf && dataAck;
    assign stDone  = (stateFf == cbbc_pkg::ST_WRITE) && toStatusFf;

    // ****************************************
    // Sequencing
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            stateFf    <= cbbc_pkg::ST_IDLE;
            cntFf      <= 3'h0;
            tgtFf      <= cbbc_pkg::PC_RESET;
            maskFf     <= 16'h0000;
            toStatusFf <= 1'b0;
            limFf      <= 1'b0;
            takenFf    <= 1'b0;
        end else begin
            case (stateFf)
                cbbc_pkg::ST_IDLE: begin
                    if (acceptBr) begin
                        stateFf <= cbbc_pkg::ST_BRANCH;
                        takenFf <= condTrue;
                        tgtFf   <= condTrue ? branchTarget :
                                   pcFf + PC_STEP_W;
                        cntFf   <= condTrue ? cbbc_pkg::BR_TAKEN_CYC - CNT_W
                                   : cbbc_pkg::BR_NOT_CYC - CNT_W;
                    end else if (accept) begin
                        stateFf    <= cbbc_pkg::ST_READ;
                        maskFf     <= bfMask;
                        toStatusFf <= bfToStatus;
                        limFf      <= limitEvent;
                    end
                end
                cbbc_pkg::ST_BRANCH: begin
                    if (cntFf == CNT_W) begin
                        stateFf <= cbbc_pkg::ST_IDLE;
                    end else begin
                        cntFf <= cntFf - CNT_W;
                    end
                end
                cbbc_pkg::ST_READ: begin
                    if (toStatusFf || dataAck) begin
                        stateFf <= cbbc_pkg::ST_WRITE;
                    end
                end
                cbbc_pkg::ST_WRITE: begin
                    if (stDone || memDone) begin
                        stateFf <= cbbc_pkg::ST_IDLE;
                    end
                end
                default: stateFf <= cbbc_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Destination access
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            opValFf     <= 16'h0000;
            dataReqFf   <= 1'b0;
            dataWeFf    <= 1'b0;
            dataAddrFf  <= 16'h0000;
            dataWdataFf <= 16'h0000;
        end else begin
            if (accept && !instrIsBranch) begin
                opValFf    <= statusFf;
                dataAddrFf <= bfAddr;
                dataReqFf  <= !bfToStatus;
                dataWeFf   <= 1'b0;
            end else if (stateFf == cbbc_pkg::ST_READ && !toStatusFf
                         && dataAck) begin
                opValFf     <= dataRdata;
                dataWeFf    <= 1'b1;
                dataWdataFf <= aluOut;
            end else if (memDone) begin
                dataReqFf <= 1'b0;
                dataWeFf  <= 1'b0;
            end
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    always_comb begin
        nxt_status = statusFf;
        if (stDone) begin
            nxt_status = opValFf ^ maskFf;
        end else if (memDone) begin
            nxt_status[cbbc_pkg::BIT_C] = allSet;
            if (limFf) begin
                nxt_status[cbbc_pkg::BIT_L] = 1'b1;
            end
        end else if (apbWr && paddr == cbbc_pkg::ADDR_STATUS) begin
            nxt_status = pwdata[15:0];
        end
    end

    // Branch path never writes here, so during it only an APB status write moves the flags
    always_ff @(posedge clock) begin
        if (srst) begin
            statusFf <= cbbc_pkg::STATUS_RESET;
        end else begin
            statusFf <= nxt_status;
        end
    end

    // ****************************************
    // Program counter
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            pcFf     <= cbbc_pkg::PC_RESET;
            pcLoadFf <= 1'b0;
            doneFf   <= 1'b0;
        end else begin
            pcLoadFf <= 1'b0;
            doneFf   <= stDone || memDone;
            if (stateFf == cbbc_pkg::ST_BRANCH && cntFf == CNT_W) begin
                pcFf     <= tgtFf;
                pcLoadFf <= 1'b1;
                doneFf   <= 1'b1;
            end else if (apbWr && paddr == cbbc_pkg::ADDR_PC) begin
                pcFf <= pwdata[15:0];
            end
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign apbWr   = psel && penable && pwrite && !pslverr;
    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     !(paddr == cbbc_pkg::ADDR_MODE ||
                       paddr == cbbc_pkg::ADDR_STATUS ||
                       paddr == cbbc_pkg::ADDR_PC ||
                       paddr == cbbc_pkg::ADDR_INFO);

    always_ff @(posedge clock) begin
        if (srst) begin
            ccModeFf <= 1'b0;
        end else if (apbWr && paddr == cbbc_pkg::ADDR_MODE) begin
            ccModeFf <= pwdata[cbbc_pkg::MODE_CC_BIT];
        end
    end

    // Set beats a simultaneous write-one clear
    always_ff @(posedge clock) begin
        if (srst) begin
            illegalFf <= 1'b0;
        end else if (acceptBr && !condLegal) begin
            illegalFf <= 1'b1;
        end else if (apbWr && paddr == cbbc_pkg::ADDR_INFO &&
                     pwdata[cbbc_pkg::INFO_ILLEGAL]) begin
            illegalFf <= 1'b0;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            cbbc_pkg::ADDR_MODE:   prdata[cbbc_pkg::MODE_CC_BIT] = ccModeFf;
            cbbc_pkg::ADDR_STATUS: prdata[15:0] = statusFf;
            cbbc_pkg::ADDR_PC:     prdata[15:0] = pcFf;
            cbbc_pkg::ADDR_INFO: begin
                prdata[cbbc_pkg::INFO_BUSY]    = !instrReady;
                prdata[cbbc_pkg::INFO_ILLEGAL] = illegalFf;
                prdata[cbbc_pkg::INFO_TAKEN]   = takenFf;
            end
            default: prdata = 32'h0000_0000;
        endcase
    end

    assign pcOut       = pcFf;
    assign pcLoad      = pcLoadFf;
    assign instrDone   = doneFf;
    assign branchTaken = takenFf;
    assign dataReq     = dataReqFf;
    assign dataWe      = dataWeFf;
    assign dataAddr    = dataAddrFf;
    assign dataWdata   = dataWdataFf;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_taken_target: assert property (acceptBr && condTrue |->
        ##6 (pcLoad && pcOut == $past(branchTarget, 6)))
        else $error("taken branch target or timing wrong");
    a_not_taken: assert property (acceptBr && !condTrue |->
        ##4 (pcLoad && pcOut == $past(pcFf, 4) + PC_STEP_W))
        else $error("untaken branch step or timing wrong");
    a_branch_quiet: assert property (
        stateFf == cbbc_pkg::ST_BRANCH && !apbWr |=> $stable(statusFf))
        else $error("branch changed status word");
    a_cc_gate: assert property (acceptBr && !ccModeFf &&
        condSel == cbbc_pkg::COND_CS |=> illegalFf && !takenFf)
        else $error("unsigned condition accepted without mode bit");
    a_write_data: assert property (dataReq && dataWe |->
        dataWdata == (opValFf ^ maskFf))
        else $error("written value not masked inversion");
    a_rmw_order: assert property ($rose(dataWe) |->
        $past(stateFf) == cbbc_pkg::ST_READ && $past(dataAck))
        else $error("write not preceded by read");
    a_carry_set: assert property (memDone |=>
        statusFf[cbbc_pkg::BIT_C] == &(~$past(maskFf) | $past(opValFf)))
        else $error("carry does not match mask test");
    a_flags_keep: assert property (memDone |=>
        statusFf[5:1] == $past(statusFf[5:1]))
        else $error("unnamed flag changed");
    a_status_dst: assert property (stDone |=>
        statusFf == ($past(opValFf) ^ $past(maskFf)))
        else $error("status destination not inverted by mask");

    c_taken: cover property (acceptBr && condTrue ##6 pcLoad);
    c_mem_rmw: cover property (memDone ##1 instrDone);
    c_status_dst: cover property (stDone);
endmodule // cbbc_core

// file: sim/cond_branch_bitfield_change_tb.sv
// Self-checking testbench for the branch and bit-field change unit
`timescale 1ns/10ps
module cond_branch_bitfield_change_tb;
    logic        clock         = 1'b0;
    logic        srst          = 1'b1;
    logic [7:0]  paddr         = 8'h00;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [31:0] pwdata        = 32'h0;
    logic        instrValid    = 1'b0;
    logic        instrIsBranch = 1'b0;
    logic [3:0]  condSel       = 4'h0;
    logic [6:0]  offset        = 7'h00;
    logic [15:0] bfMask        = 16'h0;
    logic        bfToStatus    = 1'b0;
    logic [15:0] bfAddr        = 16'h0;
    logic        limitEvent    = 1'b0;
    logic [15:0] dataRdata     = 16'h0;
    logic        dataAck       = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        instrReady;
    logic [15:0] pcOut;
    logic        pcLoad;
    logic        instrDone;
    logic        branchTaken;
    logic        dataReq;
    logic        dataWe;
    logic [15:0] dataAddr;
    logic [15:0] dataWdata;
    logic [31:0] rd;
    logic        err;
    int          n;
    int          miscompares   = 0;
    int          checks_done   = 0;
    logic [3:0]  uns [4]       = '{4'h0, 4'h1, 4'h5, 4'h7};

    cbbc_core i_cbbc_core (
        .clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instrValid(instrValid), .instrReady(instrReady),
        .instrIsBranch(instrIsBranch), .condSel(condSel),
        .offset(offset), .bfMask(bfMask), .bfToStatus(bfToStatus),
        .bfAddr(bfAddr), .limitEvent(limitEvent), .pcOut(pcOut),
        .pcLoad(pcLoad), .instrDone(instrDone),
        .branchTaken(branchTaken), .dataReq(dataReq), .dataWe(dataWe),
        .dataAddr(dataAddr), .dataWdata(dataWdata),
        .dataRdata(dataRdata), .dataAck(dataAck)
    );

    always #5 clock = ~clock;

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, seen,
                     exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic issue(input logic br, input logic [3:0] cs,
                         input logic [6:0] off, input logic [15:0] m,
                         input logic toSt, input logic lim);
        @(posedge clock);
        instrValid    <= 1'b1;
        instrIsBranch <= br;
        condSel       <= cs;
        offset        <= off;
        bfMask        <= m;
        bfToStatus    <= toSt;
        limitEvent    <= lim;
        @(posedge clock);
        instrValid <= 1'b0;
        // Flipped so a late sample of the limit input shows up
        limitEvent <= ~lim;
    endtask

    task automatic waitDone;
        // Counts cycles with the accept edge as cycle one
        n = 1;
        #1;
        while (instrDone !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    function automatic logic condExp(input logic [3:0] cs,
                                     input logic [15:0] s);
        logic c, v, z, ng, u, e;
        c = s[0];
        v = s[1];
        z = s[2];
        ng = s[3];
        u = s[4];
        e = s[5];
        case (cs)
            cbbc_pkg::COND_CC: return !c;
            cbbc_pkg::COND_CS: return c;
            cbbc_pkg::COND_HI: return !c && !z;
            cbbc_pkg::COND_LS: return c || z;
            cbbc_pkg::COND_GE: return !(ng ^ v);
            cbbc_pkg::COND_LT: return ng ^ v;
            cbbc_pkg::COND_EQ: return z;
            cbbc_pkg::COND_NE: return !z;
            cbbc_pkg::COND_GT: return !(z || (ng ^ v));
            cbbc_pkg::COND_LE: return z || (ng ^ v);
            cbbc_pkg::COND_NN: return !(z || (!u && !e));
            cbbc_pkg::COND_NR: return z || (!u && !e);
            default: return 1'b0;
        endcase
    endfunction

    task automatic branch(input logic [3:0] cs, input logic [6:0] off,
                          input logic [15:0] st, input logic [15:0] pc,
                          input logic exp);
        logic [15:0] tgt;
        tgt = exp ? pc + 16'h0001 + {{9{off[6]}}, off} : pc + 16'h0001;
        apb(cbbc_pkg::ADDR_STATUS, 1'b1, {16'h0, st});
        apb(cbbc_pkg::ADDR_PC, 1'b1, {16'h0, pc});
        issue(1'b1, cs, off, 16'h0, 1'b0, 1'b0);
        waitDone;
        chk(n, exp ? 6 : 4, "branch cycles");
        chk({31'h0, pcLoad}, 32'h1, "pc load pulse");
        chk({16'h0, pcOut}, {16'h0, tgt}, "next pc");
        chk({31'h0, branchTaken}, {31'h0, exp}, "taken flag");
        apb(cbbc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, {16'h0, st}, "status after branch");
    endtask

    task automatic bfMem(input logic [15:0] m, input logic [15:0] a,
                         input logic [15:0] v, input logic [15:0] st,
                         input logic lim, input int stall);
        logic [15:0] expSt;
        int k;
        expSt = st;
        expSt[0] = &(v | ~m);
        if (lim) begin
            expSt[6] = 1'b1;
        end
        apb(cbbc_pkg::ADDR_STATUS, 1'b1, {16'h0, st});
        bfAddr <= a;
        dataRdata <= ~v;
        issue(1'b0, 4'h0, 7'h00, m, 1'b0, lim);
        k = 0;
        #1;
        while (dataReq !== 1'b1 && k < 20) begin
            @(posedge clock);
            #1;
            k++;
        end
        repeat (stall) @(posedge clock);
        #1;
        chk({30'h0, dataReq, dataWe}, 32'h2, "read request");
        chk({16'h0, dataAddr}, {16'h0, a}, "read address");
        @(posedge clock);
        dataAck   <= 1'b1;
        dataRdata <= v;
        @(posedge clock);
        dataAck   <= 1'b0;
        dataRdata <= ~v;
        k = 0;
        #1;
        while (dataWe !== 1'b1 && k < 20) begin
            @(posedge clock);
            #1;
            k++;
        end
        repeat (stall) @(posedge clock);
        #1;
        chk({15'h0, dataReq, dataWdata}, {15'h0, 1'b1, v ^ m},
            "write data");
        chk({16'h0, dataAddr}, {16'h0, a}, "write address");
        @(posedge clock);
        dataAck <= 1'b1;
        @(posedge clock);
        dataAck <= 1'b0;
        waitDone;
        chk({30'h0, instrDone, dataReq}, 32'h2, "one write only");
        apb(cbbc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, {16'h0, expSt}, "flags");
    endtask

    // ****************************************
    // Closing and watchdog
    // ****************************************
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Tests need about 15k cycles; generous margin
    initial begin
        #600000;
        miscompares++;
        summarize;
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            apb(8'(a * 4), 1'b0, 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        chk({31'h0, instrReady}, 32'h1, "idle after reset");
        apb(8'h10, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        $display("test reset and map done");

        apb(cbbc_pkg::ADDR_MODE, 1'b1, 32'h1);
        for (int cs = 0; cs < 16; cs++) begin
            for (int f = 0; f < 64; f++) begin
                branch(4'(cs), 7'(cs * 11 + f), 16'(f),
                       16'h7ff0 ^ 16'(f * 37), condExp(4'(cs), 16'(f)));
            end
        end
        $display("test branch conditions done");
        apb(cbbc_pkg::ADDR_INFO, 1'b0, 32'h0);
        chk({31'h0, rd[1]}, 32'h1, "illegal code flag");
        apb(cbbc_pkg::ADDR_INFO, 1'b1, 32'h2);

        apb(cbbc_pkg::ADDR_MODE, 1'b1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            branch(uns[i], 7'h10, (i == 1 || i == 3) ? 16'h0001 : 16'h0,
                   16'h0200, 1'b0);
        end
        apb(cbbc_pkg::ADDR_INFO, 1'b0, 32'h0);
        chk({31'h0, rd[1]}, 32'h1, "illegal flag");
        apb(cbbc_pkg::ADDR_INFO, 1'b1, 32'h2);
        apb(cbbc_pkg::ADDR_INFO, 1'b0, 32'h0);
        chk({31'h0, rd[1]}, 32'h0, "illegal cleared");
        $display("test unsigned gating done");

        bfMem(16'h0310, 16'hffe2, 16'h0010, 16'h002f, 1'b0, 0);
        bfMem(16'h0310, 16'h1234, 16'h0310, 16'h0000, 1'b1, 3);
        bfMem(16'h0000, 16'h0040, 16'ha5a5, 16'h0010, 1'b0, 1);
        bfMem(16'hffff, 16'h8000, 16'hffff, 16'h0040, 1'b0, 0);
        $display("test memory bit field done");

        apb(cbbc_pkg::ADDR_STATUS, 1'b1, 32'h0055);
        issue(1'b0, 4'h0, 7'h00, 16'h00f3, 1'b1, 1'b1);
        waitDone;
        chk(n, 3, "status dest cycles");
        chk({31'h0, dataReq}, 32'h0, "status dest no bus");
        apb(cbbc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h00a6, "status dest result");
        $display("test status bit field done");
        summarize;
    end
endmodule // cond_branch_bitfield_change_tb
